/* hdl/hsc_pkg.sv */
// constants and types for the field conversion sequencer
// Summary of operation
// - each conversion gives a 15-bit unsigned code proportional to field, readable by host
// - in continuous mode active state refreshes the output repeatedly at the bandwidth-selected interval
// - standby stops sampling and keeps every register including the last result
// - standby serves only result reads, mode setup access and start field access
// - 2-bit mode: 00/10 continuous, 01 one-shot, 11 duty-cycled; direct or stored copy
// - continuous mode stays active and updates output after every conversion
// - one-shot converts once, enters standby, waits there for a new start command
// - writing 1 to command bit 12 forces active state and one sample
// - duty-cycled mode alternates states itself; period is active plus standby time
// - duty active time follows bandwidth field 25:23, oversampling bit and filter enable
// - duty standby time comes from 3-bit timer field at bits 5:3
// - timer codes 0..7 give 0.125, 0.25, 0.5, 1, 10, 100, 500, 1000 ms
// - power-on starts active; first automatic standby follows one conversion
// - bipolar centred offset sits near 16383 at zero field, slope sign by polarity
// - bipolar coarse offset can move the zero-field code to 8191 or 24575
// - quarter or three-quarter offset doubles the slope of the centred case
// - unipolar answers one field direction, zero field at 0% or 100% by polarity
// - omnipolar uses field magnitude, zero field at 0% or 100% by polarity
// - polarity inverts output slope in every output mode
// - output mode 01 unipolar south, 10 unipolar north, 11 omnipolar
// - offset 00 gives 8191/24575, 01 or 10 gives 16383, 11 gives 24575/8191
package hsc_pkg;

   localparam logic [5:0]  ADDR_RESULT = 6'h12;
   localparam logic [5:0]  ADDR_MODE   = 6'h14;
   localparam logic [5:0]  ADDR_CMD    = 6'h16;
   localparam int          START_BIT   = 12;
   localparam int          STBY_HI     = 5;
   localparam int          STBY_LO     = 3;
   localparam int          BW_HI       = 25;
   localparam int          BW_LO       = 23;
   localparam logic [15:0] MODE_RST    = 16'h0000;
   localparam logic [14:0] CODE_MAX    = 15'h7FFF;
   localparam logic [14:0] Q_MID       = 15'h3FFF;
   localparam logic [14:0] Q_LOW       = 15'h1FFF;
   localparam logic [14:0] Q_HIGH      = 15'h5FFF;
   localparam logic [3:0]  BW_OFF_IDX  = 4'h8;
   localparam int unsigned CLK_NS      = 4;

   typedef int unsigned hsc_ns9_t [0:8];
   typedef int unsigned hsc_ns8_t [0:7];

   // active time per bandwidth code, last entry with the filter off
   localparam hsc_ns9_t ACT_NS = '{2100000, 1000000, 570000, 310000,
      180000, 110000, 85000, 65000, 60000};
   localparam hsc_ns9_t ACT_OSR_NS = '{3800000, 1900000, 1000000, 530000,
      300000, 180000, 120000, 90000, 75000};
   localparam hsc_ns8_t STBY_NS = '{125000, 250000, 500000, 1000000,
      10000000, 100000000, 500000000, 1000000000};

   typedef enum logic [1:0] {
      CM_CONT0 = 2'b00,
      CM_ONE   = 2'b01,
      CM_CONT2 = 2'b10,
      CM_DUTY  = 2'b11
   } hsc_conv_t;

   typedef enum logic [1:0] {
      OM_BIPOLAR = 2'b00,
      OM_UNI_S   = 2'b01,
      OM_UNI_N   = 2'b10,
      OM_OMNI    = 2'b11
   } hsc_out_t;

   typedef enum logic {
      PS_ACTIVE  = 1'b0,
      PS_STANDBY = 1'b1
   } hsc_pstate_t;

endpackage

/* hdl/hsc_conv_seq.sv */
// conversion sequencer, power state control and output code formatter
`timescale 1ns/1ps
`default_nettype none

module hsc_conv_seq #(
   parameter hsc_pkg::hsc_ns9_t ACT_NS_P     = hsc_pkg::ACT_NS,
   parameter hsc_pkg::hsc_ns9_t ACT_OSR_NS_P = hsc_pkg::ACT_OSR_NS,
   parameter hsc_pkg::hsc_ns8_t STBY_NS_P    = hsc_pkg::STBY_NS
) (
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire logic [5:0]         reg_addr,
   input  wire logic [15:0]        reg_wdata,
   output var  logic [15:0]        reg_rdata,
   output var  logic               reg_rvalid,
   input  wire logic [31:0]        cfg_word_four,
   input  wire logic [1:0]         conversion_select_stored,
   input  wire logic               double_sample_average,
   input  wire logic               recursive_filter_on,
   input  wire logic               slope_invert,
   input  wire logic [1:0]         zero_shift,
   input  wire logic [1:0]         output_mode,
   input  wire logic signed [15:0] raw_field,
   output var  logic [14:0]        field_code_value,
   output var  logic               active_state,
   output var  logic               conv_done
);

   hsc_pkg::hsc_pstate_t state_r;
   hsc_pkg::hsc_pstate_t state_nxt;
   logic [31:0]          ns_r;
   logic [31:0]          ns_nxt;
   logic [32:0]          ns_sum;
   logic [31:0]          tgt;
   logic                 tmr_done;
   logic                 conv_fire;
   logic                 start_wr;
   logic [15:0]          mode_reg_r;
   logic                 init_pend_r;
   logic                 active_r;
   logic [14:0]          result_r;
   logic                 conv_done_r;
   logic [15:0]          rdata_r;
   logic                 rvalid_r;
   logic [3:0]           act_idx;
   logic [2:0]           stby_code;
   hsc_pkg::hsc_conv_t   conv_sel;
   logic [14:0]          code_calc;
   logic [14:0]          quiescent;
   logic signed [17:0]   fld;
   logic signed [17:0]   vdir;
   logic signed [17:0]   mag;
   logic signed [17:0]   sum;

   assign conv_sel  = hsc_pkg::hsc_conv_t'(mode_reg_r[1:0]);
   assign stby_code = mode_reg_r[hsc_pkg::STBY_HI:hsc_pkg::STBY_LO];

   // the only command field; other command bits are ignored
   assign start_wr = reg_wr
                   && (reg_addr == hsc_pkg::ADDR_CMD)
                   && reg_wdata[hsc_pkg::START_BIT];

   // timing

   // disabled filter overrides the bandwidth code
   always_comb begin
      if (recursive_filter_on) begin
         act_idx = {1'b0, cfg_word_four[hsc_pkg::BW_HI:hsc_pkg::BW_LO]};
      end else begin
         act_idx = hsc_pkg::BW_OFF_IDX;
      end
   end

   always_comb begin
      if (state_r == hsc_pkg::PS_STANDBY) begin
         tgt = STBY_NS_P[stby_code];
      end else if (double_sample_average) begin
         tgt = ACT_OSR_NS_P[act_idx];
      end else begin
         tgt = ACT_NS_P[act_idx];
      end
   end

   // elapsed time is kept in ns so a least time rounds up to a whole cycle
   assign ns_sum   = {1'b0, ns_r} + 33'(hsc_pkg::CLK_NS);
   assign tmr_done = (ns_sum >= {1'b0, tgt});
   assign conv_fire = (state_r == hsc_pkg::PS_ACTIVE) && tmr_done;

   // power state

   always_comb begin
      state_nxt = state_r;
      ns_nxt    = ns_sum[31:0];
      if (start_wr) begin
         state_nxt = hsc_pkg::PS_ACTIVE;
         ns_nxt    = '0;
      end else begin
         case (state_r)
            hsc_pkg::PS_ACTIVE: begin
               if (tmr_done) begin
                  ns_nxt = '0;
                  case (conv_sel)
                     hsc_pkg::CM_ONE: begin
                        state_nxt = hsc_pkg::PS_STANDBY;
                     end
                     hsc_pkg::CM_DUTY: begin
                        state_nxt = hsc_pkg::PS_STANDBY;
                     end
                     default: begin
                        state_nxt = hsc_pkg::PS_ACTIVE;
                     end
                  endcase
               end
            end
            hsc_pkg::PS_STANDBY: begin
               case (conv_sel)
                  hsc_pkg::CM_ONE: begin
                     // waits for a start command, time frozen
                     ns_nxt = ns_r;
                  end
                  hsc_pkg::CM_DUTY: begin
                     if (tmr_done) begin
                        state_nxt = hsc_pkg::PS_ACTIVE;
                        ns_nxt    = '0;
                     end
                  end
                  default: begin
                     state_nxt = hsc_pkg::PS_ACTIVE;
                     ns_nxt    = '0;
                  end
               endcase
            end
            default: begin
               state_nxt = hsc_pkg::PS_ACTIVE;
               ns_nxt    = '0;
            end
         endcase
      end
   end

   // power-on always lands in active with a fresh conversion
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r <= hsc_pkg::PS_ACTIVE;
         ns_r    <= '0;
      end else begin
         state_r <= state_nxt;
         ns_r    <= ns_nxt;
      end
   end

   // power state output gets its own flop so the pin sees no decode logic
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         active_r <= 1'b1;
      end else begin
         active_r <= (state_nxt == hsc_pkg::PS_ACTIVE);
      end
   end

   // output code

   always_comb begin
      case (zero_shift)
         2'b00: begin
            quiescent = slope_invert ? hsc_pkg::Q_HIGH : hsc_pkg::Q_LOW;
         end
         2'b11: begin
            quiescent = slope_invert ? hsc_pkg::Q_LOW : hsc_pkg::Q_HIGH;
         end
         default: begin
            quiescent = hsc_pkg::Q_MID;
         end
      endcase
   end

   // raw_field is scaled at the unipolar slope; centred bipolar halves it
   always_comb begin
      fld  = 18'(raw_field);
      vdir = slope_invert ? -fld : fld;
      mag  = '0;
      sum  = '0;
      case (hsc_pkg::hsc_out_t'(output_mode))
         hsc_pkg::OM_UNI_S: begin
            mag = (fld > 0) ? fld : 18'sh0;
         end
         hsc_pkg::OM_UNI_N: begin
            mag = (fld < 0) ? -fld : 18'sh0;
         end
         hsc_pkg::OM_OMNI: begin
            mag = (fld < 0) ? -fld : fld;
         end
         default: begin
            mag = '0;
         end
      endcase
      if (output_mode == hsc_pkg::OM_BIPOLAR) begin
         if (zero_shift == 2'b00 || zero_shift == 2'b11) begin
            sum = $signed({3'h0, quiescent}) + vdir;
         end else begin
            sum = $signed({3'h0, quiescent}) + (vdir >>> 1);
         end
      end else if (slope_invert) begin
         sum = $signed({3'h0, hsc_pkg::CODE_MAX}) - mag;
      end else begin
         sum = mag;
      end
   end

   // saturate instead of wrapping when the field overruns the range
   always_comb begin
      if (sum < 0) begin
         code_calc = '0;
      end else if (sum > $signed({3'h0, hsc_pkg::CODE_MAX})) begin
         code_calc = hsc_pkg::CODE_MAX;
      end else begin
         code_calc = sum[14:0];
      end
   end

   // result is held across standby, only a finished conversion updates it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         result_r    <= '0;
         conv_done_r <= 1'b0;
      end else begin
         conv_done_r <= conv_fire;
         if (conv_fire) begin
            result_r <= code_calc;
         end
      end
   end

   // registers

   // direct setup copy is seeded from the stored copy once after reset;
   // a port cannot be sampled under reset, so the load waits one cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_reg_r  <= hsc_pkg::MODE_RST;
         init_pend_r <= 1'b1;
      end else if (reg_wr && reg_addr == hsc_pkg::ADDR_MODE) begin
         mode_reg_r  <= reg_wdata;
         init_pend_r <= 1'b0;
      end else if (init_pend_r) begin
         mode_reg_r[1:0] <= conversion_select_stored;
         mode_reg_r[hsc_pkg::STBY_HI:hsc_pkg::STBY_LO]
            <= cfg_word_four[hsc_pkg::STBY_HI:hsc_pkg::STBY_LO];
         init_pend_r <= 1'b0;
      end
   end

   // only three addresses exist here, which is all standby may reach
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_r  <= '0;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               hsc_pkg::ADDR_RESULT: begin
                  rdata_r <= {1'b0, result_r};
               end
               hsc_pkg::ADDR_MODE: begin
                  rdata_r <= mode_reg_r;
               end
               hsc_pkg::ADDR_CMD: begin
                  // start reads back as zero; bit 0 shows the power state
                  rdata_r <= {15'h0000, state_r == hsc_pkg::PS_ACTIVE};
               end
               default: begin
                  rdata_r <= 16'h0000;
               end
            endcase
         end
      end
   end

   assign reg_rdata        = rdata_r;
   assign reg_rvalid       = rvalid_r;
   assign field_code_value = result_r;
   assign active_state     = active_r;
   assign conv_done        = conv_done_r;

   // checks

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_oneshot_end;
      conv_fire && conv_sel == hsc_pkg::CM_ONE && !start_wr;
   endsequence

   sequence s_duty_wake;
      state_r == hsc_pkg::PS_STANDBY && conv_sel == hsc_pkg::CM_DUTY
         && tmr_done && !start_wr;
   endsequence

   a_result_load:
   assert property (conv_fire |=> field_code_value == $past(code_calc) && conv_done)
   else $error("result not loaded from finished conversion");

   a_standby_hold:
   assert property (state_r == hsc_pkg::PS_STANDBY |=> $stable(result_r))
   else $error("result changed during standby");

   a_cont_active:
   assert property ((conv_sel == hsc_pkg::CM_CONT0 || conv_sel == hsc_pkg::CM_CONT2)
                    |=> active_state)
   else $error("continuous mode left active state");

   a_oneshot_stby:
   assert property (s_oneshot_end |=> !active_state
                    ##1 (!active_state || $past(start_wr) || $past(conv_sel) != hsc_pkg::CM_ONE))
   else $error("one-shot did not settle in standby");

   a_start_cmd:
   assert property (start_wr |=> active_state && ns_r == 32'h0000_0000)
   else $error("start command did not restart a conversion");

   a_duty_wake:
   assert property (s_duty_wake |=> active_state ##0 ns_r == 32'h0000_0000)
   else $error("duty cycle did not wake after standby time");

   a_zero_shift_q:
   assert property (output_mode == hsc_pkg::OM_BIPOLAR && raw_field == 16'sh0000
                    |-> code_calc == quiescent
                        && (zero_shift != 2'b00 || code_calc == (slope_invert ? 15'h5FFF : 15'h1FFF)))
   else $error("bipolar zero-field code wrong");

   a_uni_zero:
   assert property (output_mode != hsc_pkg::OM_BIPOLAR && raw_field == 16'sh0000
                    |-> code_calc == (slope_invert ? 15'h7FFF : 15'h0000))
   else $error("unipolar or omnipolar zero-field code wrong");

   a_powerup_active:
   assert property ($fell(rst) |-> active_state)
   else $error("power-up not in active state");

endmodule

`default_nettype wire

/* test/hsc_host_model.sv */
// host side model driving the register port of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module hsc_host_model (
   input  wire logic        clk_sys,
   output var  logic        reg_wr,
   output var  logic        reg_rd,
   output var  logic [5:0]  reg_addr,
   output var  logic [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h3F;
      reg_wdata = 16'hA5A5;
   end

   // the bench only issues result, mode and start accesses while the block sleeps
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      // released bus carries inverted values so a stale word cannot pass as fresh
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rvalid ? reg_rdata : 16'hxxxx;
   endtask
endmodule

`default_nettype wire

/* test/hall_sensor_conversion_power_control_tb.sv */
// self-checking bench for the field conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module hall_sensor_conversion_power_control_tb;
   // short active and standby times keep the run brief
   localparam hsc_pkg::hsc_ns9_t ACT_P = '{72, 68, 64, 60, 56, 52, 48, 44, 40};
   localparam hsc_pkg::hsc_ns9_t OSR_P = '{112, 108, 104, 100, 96, 92, 88, 84, 80};
   localparam hsc_pkg::hsc_ns8_t STB_P = '{40, 60, 80, 100, 120, 140, 160, 180};

   logic               clk_sys = 1'b0;
   logic               rst = 1'b1;
   logic               reg_wr;
   logic               reg_rd;
   logic [5:0]         reg_addr;
   logic [15:0]        reg_wdata;
   logic [15:0]        reg_rdata;
   logic               reg_rvalid;
   logic [31:0]        cfg_word_four = 32'h0000_0010;
   logic [1:0]         conversion_select_stored = 2'b11;
   logic               double_sample_average = 1'b0;
   logic               recursive_filter_on = 1'b1;
   logic               slope_invert = 1'b0;
   logic [1:0]         zero_shift = 2'b01;
   logic [1:0]         output_mode = 2'b00;
   logic signed [15:0] raw_field = 16'sd0;
   logic [14:0]        field_code_value;
   logic               active_state;
   logic               conv_done;
   int                 err_count = 0;
   int                 n_tests = 0;

   always #2 clk_sys = ~clk_sys;

   hsc_conv_seq #(.ACT_NS_P(ACT_P), .ACT_OSR_NS_P(OSR_P), .STBY_NS_P(STB_P)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .cfg_word_four(cfg_word_four), .conversion_select_stored(conversion_select_stored),
      .double_sample_average(double_sample_average), .recursive_filter_on(recursive_filter_on),
      .slope_invert(slope_invert), .zero_shift(zero_shift), .output_mode(output_mode),
      .raw_field(raw_field), .field_code_value(field_code_value),
      .active_state(active_state), .conv_done(conv_done));

   hsc_host_model host_u (
      .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
         err_count++;
      end
   endtask

   task automatic close_out;
      if (err_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   function automatic logic [31:0] exp_code(input int om, input int inv, input int zs, input int raw);
      int v;
      int c;
      v = inv ? -raw : raw;
      if (om == 0 && (zs == 1 || zs == 2))
         c = 16383 + (v >>> 1);
      else if (om == 0)
         c = (((zs == 0) != (inv != 0)) ? 8191 : 24575) + v;
      else begin
         c = (om == 1) ? raw : (om == 2) ? -raw : (raw < 0 ? -raw : raw);
         c = inv ? 32767 - c : c;
      end
      c = (c < 0) ? 0 : (c > 32767) ? 32767 : c;
      return 32'(c);
   endfunction

   // waits past at least one edge so a pulse already seen is not counted twice
   task automatic wait_done;
      int g;
      g = 0;
      do begin
         @(negedge clk_sys);
         g++;
      end while (g < 500 && conv_done !== 1'b1);
      check("conversion done", conv_done, 1'b1);
   endtask

   task automatic run_len(input logic lvl, output int n);
      int g;
      n = 0;
      for (g = 0; g < 2000 && active_state === lvl; g++) @(negedge clk_sys);
      for (g = 0; g < 2000 && active_state !== lvl; g++) @(negedge clk_sys);
      while (n < 2000 && active_state === lvl) begin
         n++;
         @(negedge clk_sys);
      end
   endtask

   task automatic t_reset;
      logic [15:0] d;
      check("active after reset", active_state, 1'b1);
      check("code after reset", field_code_value, 15'h0000);
      host_u.rd(hsc_pkg::ADDR_MODE, d);
      check("seeded mode", d, hsc_pkg::MODE_RST | 16'h0013);
      wait_done;
      check("first standby", active_state, 1'b0);
   endtask

   task automatic t_duty;
      int k;
      int hi;
      int lo;
      int e;
      host_u.wr(hsc_pkg::ADDR_MODE, 16'h0003);
      for (k = 0; k < 18; k++) begin
         @(negedge clk_sys);
         double_sample_average = (k >= 9);
         recursive_filter_on = (k % 9 != 8);
         cfg_word_four[25:23] = 3'(k % 9);
         e = ((k >= 9 ? OSR_P[k % 9] : ACT_P[k % 9]) + 3) / 4;
         run_len(1'b1, hi);
         run_len(1'b0, lo);
         check("active cycles", hi, e);
         check("sample period", hi + lo, e + STB_P[0] / 4);
      end
      for (k = 0; k < 8; k++) begin
         host_u.wr(hsc_pkg::ADDR_MODE, 16'(k << 3) | 16'h0003);
         run_len(1'b1, hi);
         run_len(1'b0, lo);
         check("standby cycles", lo, (STB_P[k] + 3) / 4);
      end
   endtask

   task automatic t_codes;
      int tc [13][4] = '{'{0, 0, 1, 100}, '{0, 1, 2, 100}, '{0, 0, 0, -200}, '{0, 1, 0, 300},
         '{0, 0, 3, 20000}, '{0, 1, 3, 50}, '{1, 0, 1, 500}, '{1, 1, 1, 500},
         '{2, 0, 1, -700}, '{3, 0, 1, -900}, '{3, 1, 1, 900}, '{0, 0, 1, -7}, '{0, 0, 0, -9000}};
      logic [15:0] d;
      int i;
      logic [31:0] e;
      host_u.wr(hsc_pkg::ADDR_MODE, 16'h0000);
      for (i = 0; i < 13; i++) begin
         output_mode = 2'(tc[i][0]);
         slope_invert = tc[i][1][0];
         zero_shift = 2'(tc[i][2]);
         raw_field = 16'(tc[i][3]);
         wait_done;
         wait_done;
         e = exp_code(tc[i][0], tc[i][1], tc[i][2], tc[i][3]);
         if (tc[i][0] == 0)
            check("bipolar code", field_code_value, e);
         else
            check("unipolar code", field_code_value, e);
         host_u.rd(hsc_pkg::ADDR_RESULT, d);
         check("result word", d, e);
      end
   endtask

   task automatic t_oneshot;
      logic [15:0] d;
      logic [14:0] c0;
      int i;
      int n;
      output_mode = 2'b00;
      slope_invert = 1'b0;
      zero_shift = 2'b01;
      raw_field = 16'sd1000;
      host_u.wr(hsc_pkg::ADDR_MODE, 16'h0001);
      wait_done;
      check("standby after one", active_state, 1'b0);
      c0 = field_code_value;
      raw_field = 16'sd2000;
      n = 0;
      for (i = 0; i < 40; i++) begin
         @(negedge clk_sys);
         n += int'(conv_done !== 1'b0) + int'(active_state !== 1'b0);
      end
      check("standby quiet", n, 0);
      // only mode, result and start accesses are legal while asleep
      host_u.wr(hsc_pkg::ADDR_MODE, 16'hA501);
      host_u.rd(hsc_pkg::ADDR_MODE, d);
      check("mode in standby", d, 16'hA501);
      host_u.wr(hsc_pkg::ADDR_CMD, 16'hEFFF);
      host_u.rd(hsc_pkg::ADDR_RESULT, d);
      check("kept result", d, {1'b0, c0});
      host_u.rd(hsc_pkg::ADDR_CMD, d);
      check("no start", d, 16'h0000);
      host_u.wr(hsc_pkg::ADDR_CMD, 16'(1) << hsc_pkg::START_BIT);
      check("start wakes", active_state, 1'b1);
      wait_done;
      check("one sample", field_code_value, exp_code(0, 0, 1, 2000));
      check("back to standby", active_state, 1'b0);
   endtask

   task automatic t_cont;
      int i;
      int k;
      int n;
      int s;
      double_sample_average = 1'b0;
      recursive_filter_on = 1'b1;
      cfg_word_four[25:23] = 3'b000;
      for (k = 0; k < 2; k++) begin
         host_u.wr(hsc_pkg::ADDR_MODE, 16'(k << 1));
         @(negedge clk_sys);
         check("wake on continuous", active_state, 1'b1);
         wait_done;
         n = 0;
         s = 0;
         for (i = 0; i < 180; i++) begin
            @(negedge clk_sys);
            n += int'(conv_done === 1'b1);
            s += int'(active_state !== 1'b1);
         end
         check("never standby", s, 0);
         check("conversions", n, 180 / ((ACT_P[0] + 3) / 4));
      end
   endtask

   initial begin
      #100000;
      err_count++;
      close_out;
   end

   initial begin
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      t_reset;
      t_duty;
      t_codes;
      t_oneshot;
      t_cont;
      close_out;
   end
endmodule

`default_nettype wire
